// >>> dtlps_top.sv
/*
 * Test loops, pattern generator, bit-error meter, front panel indicators and
 * status registers of a paired DSL modem card, reached over APB.
 * Assumes framer status, bit strobe and data come from logic on MCLK;
 * panel switches and the role strap are asynchronous pins.
 */
// Operation
// - Power indicator flashes in self-test, then solid
// - Line indicator flashes training, solid on link
// - Serial indicator solid while serial port active
// - Test indicator solid in test, blinks on error
// - Loop mode off/local/remote from panel or console
// - Local loop returns serial data to serial side
// - Local loop after generator; clean pattern, no errors
// - Remote loop returns line data onto line
// - Pattern off/plain/with errors from panel or console
// - Running pattern replaces serial data on line outside local loop; line idles in local loop
// - Meter runs with generator, checks receive data
// - Meter reports errors when pattern not returned
// - Error variant corrupts bits, forcing meter bit errors
// - Serial port circuit side unless strap selects terminal
`default_nettype none

module dtlps_top #(
    parameter int unsigned BLINK_HALF_CYCLES = dtlps_pkg::BLINK_HALF_CYC
) (
    // Clock and reset
    input  wire logic                      MCLK,
    input  wire logic                      RST_N,
    // APB slave
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [dtlps_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [31:0]               PWDATA,
    output var  logic [31:0]               PRDATA,
    output var  logic                      PREADY,
    output var  logic                      PSLVERR,
    // Asynchronous pins
    input  wire logic [1:0]                PANEL_LOOP,
    input  wire logic [1:0]                PANEL_PAT,
    input  wire logic                      ROLE_STRAP_DTE,
    // Framer status
    input  wire logic                      POWER_ON_SELF_TEST_DONE,
    input  wire logic                      TRAINING,
    input  wire logic                      LINK_UP,
    input  wire logic                      SER_ACTIVE,
    // Bit streams
    input  wire logic                      BIT_EN,
    input  wire logic                      SER_TX_DATA,
    input  wire logic                      DSL_RX_DATA,
    input  wire logic                      REMOTE_LOOP_CMD,
    output var  logic                      DSL_TX_DATA,
    output var  logic                      SER_RX_DATA,
    output var  logic                      REMOTE_LOOP_REQ,
    output var  logic                      SER_ROLE_DTE,
    // Indicators and interrupt
    output var  logic                      LED_POWER,
    output var  logic                      LED_LINE,
    output var  logic                      LED_SERIAL,
    output var  logic                      LED_TEST,
    output var  logic                      IRQ
);
    import dtlps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [4:0]             pin_s1_q, pin_s2_q;      // Switch and strap synchroniser
    logic                   role_dte_q;              // Strap captured once
    logic [1:0]             cap_cnt_q;               // Edges until strap is valid
    logic [CTRL_W-1:0]      ctrl_q, ctrl_d;          // Control register
    logic [EV_W-1:0]        int_stat_q, int_stat_d;  // Sticky events
    logic [EV_W-1:0]        int_en_q, int_en_d;      // Event enables
    logic [31:0]            prdata_q, prdata_d;      // Read data
    logic                   pslverr_q, pslverr_d;    // Unmapped address
    logic                   pready_q;                // Access phase follows setup
    logic [31:0]            status;                  // Live status word
    logic [EV_W-1:0]        ev;                      // Events this cycle
    logic [1:0]             loop_bits, pat_bits;     // Selected mode source
    dtlps_loop_e            loop_sel, loop_q;        // Requested, active loop
    dtlps_pat_e             pat_sel, pat_q;          // Requested, active pattern
    dtlps_meter_e           meter_q, meter_d;        // Meter state
    logic [4:0]             sync_cnt_q, sync_cnt_d;  // Checker fill count
    logic [15:0]            err_cnt_q, err_cnt_d;    // Detected bit errors
    logic                   err_seen_q, err_seen_d;  // Error since mode start
    logic [7:0]             inj_cnt_q, inj_cnt_d;    // Injection spacing
    logic                   tx_q, tx_d, srx_q, srx_d;// Line and serial outputs
    logic                   rdl_q;                   // Remote loop request
    logic                   mode_chg, local_test, inject, tx_bit, meter_in;
    logic                   gen_bit, chk_err, bit_err;
    logic [BLINK_CNT_W-1:0] blink_cnt_q, blink_cnt_d;// Flash divider
    logic                   blink_q, blink_d, link_q;
    logic [4:0]             led_q, led_d;            // Power, line, serial, test, irq
    logic                   apb_wr, apb_setup;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and strap capture after reset release
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1_q   <= 5'h00;
            pin_s2_q   <= 5'h00;
            role_dte_q <= 1'b0;
            cap_cnt_q  <= 2'h0;
        end else begin
            pin_s1_q <= {ROLE_STRAP_DTE, PANEL_PAT, PANEL_LOOP};
            pin_s2_q <= pin_s1_q;
            // Strap read until both synchroniser stages hold the pin
            if (cap_cnt_q != 2'h3) begin
                cap_cnt_q  <= cap_cnt_q + 2'h1;
                role_dte_q <= pin_s2_q[4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode selection: panel switches or console register
    always_comb begin
        loop_bits = ctrl_q[CTRL_PANEL_BIT] ? pin_s2_q[1:0] : ctrl_q[CTRL_LOOP_LSB +: 2];
        pat_bits  = ctrl_q[CTRL_PANEL_BIT] ? pin_s2_q[3:2] : ctrl_q[CTRL_PAT_LSB +: 2];
        case (loop_bits)
            2'h1:    loop_sel = LOOP_LAL;
            2'h2:    loop_sel = LOOP_RDL;
            default: loop_sel = LOOP_OFF;
        endcase
        case (pat_bits)
            2'h1:    pat_sel = PAT_PRBS;
            2'h2:    pat_sel = PAT_PRBS_ERR;
            default: pat_sel = PAT_OFF;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pattern generator and meter checker
    dtlps_prbs9 u_gen (
        .clk   (MCLK),
        .rst_n (RST_N),
        .step  (BIT_EN && pat_q != PAT_OFF),
        .clr   (mode_chg),
        .check (1'b0),
        .din   (1'b0),
        .bit_o (gen_bit),
        .err_o ()
    );

    dtlps_prbs9 u_chk (
        .clk   (MCLK),
        .rst_n (RST_N),
        .step  (BIT_EN && meter_q != MTR_IDLE),
        .clr   (mode_chg),
        .check (1'b1),
        .din   (meter_in),
        .bit_o (),
        .err_o (chk_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data path and meter next state
    always_comb begin
        mode_chg   = (loop_sel != loop_q) || (pat_sel != pat_q);
        local_test = (loop_q != LOOP_OFF) || (pat_q != PAT_OFF);
        inject     = (pat_q == PAT_PRBS_ERR) && (inj_cnt_q == INJECT_PERIOD_M1);
        if (pat_q != PAT_OFF) begin
            tx_bit = gen_bit ^ inject;
        end else if (REMOTE_LOOP_CMD && !local_test) begin
            tx_bit = DSL_RX_DATA;
        end else begin
            tx_bit = SER_TX_DATA;
        end
        // Local loop sits after generator so meter sees own pattern
        meter_in = (loop_q == LOOP_LAL) ? tx_bit : DSL_RX_DATA;
        bit_err  = 1'b0;
        tx_d     = tx_q;
        srx_d    = srx_q;
        if (BIT_EN) begin
            tx_d  = (loop_q == LOOP_LAL) ? IDLE_BIT : tx_bit;
            srx_d = (loop_q == LOOP_LAL) ? tx_bit : DSL_RX_DATA;
        end
        inj_cnt_d  = inj_cnt_q;
        meter_d    = meter_q;
        sync_cnt_d = sync_cnt_q;
        err_cnt_d  = err_cnt_q;
        err_seen_d = err_seen_q;
        if (mode_chg) begin
            // Any mode change restarts generator, checker and counts
            meter_d    = (pat_sel != PAT_OFF) ? MTR_SYNC : MTR_IDLE;
            sync_cnt_d = 5'h00;
            err_cnt_d  = 16'h0000;
            err_seen_d = 1'b0;
            inj_cnt_d  = 8'h00;
        end else begin
            if (BIT_EN && pat_q != PAT_OFF) begin
                inj_cnt_d = inj_cnt_q + 8'h01;
            end
            case (meter_q)
                MTR_IDLE: begin
                    meter_d = MTR_IDLE;
                end
                MTR_SYNC: begin
                    // Two fills: stale bits still in a loop drain before counting
                    if (BIT_EN) begin
                        sync_cnt_d = sync_cnt_q + 5'h01;
                        if (sync_cnt_q == {SYNC_BITS, 1'b0} - 5'h01) begin
                            meter_d = MTR_RUN;
                        end
                    end
                end
                MTR_RUN: begin
                    if (BIT_EN && chk_err) begin
                        bit_err    = 1'b1;
                        err_seen_d = 1'b1;
                        if (err_cnt_q != ERR_CNT_MAX) begin
                            err_cnt_d = err_cnt_q + 16'h0001;
                        end
                    end
                end
                default: begin
                    meter_d = MTR_IDLE;
                end
            endcase
        end
    end

    // Data path and meter registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            loop_q     <= LOOP_OFF;
            pat_q      <= PAT_OFF;
            meter_q    <= MTR_IDLE;
            sync_cnt_q <= 5'h00;
            err_cnt_q  <= 16'h0000;
            err_seen_q <= 1'b0;
            inj_cnt_q  <= 8'h00;
            tx_q       <= IDLE_BIT;
            srx_q      <= IDLE_BIT;
            rdl_q      <= 1'b0;
        end else begin
            loop_q     <= loop_sel;
            pat_q      <= pat_sel;
            meter_q    <= meter_d;
            sync_cnt_q <= sync_cnt_d;
            err_cnt_q  <= err_cnt_d;
            err_seen_q <= err_seen_d;
            inj_cnt_q  <= inj_cnt_d;
            tx_q       <= tx_d;
            srx_q      <= srx_d;
            rdl_q      <= (loop_sel == LOOP_RDL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB registers; reads sampled in setup, ready in the access phase
    always_comb begin
        apb_setup  = PSEL && !PENABLE;
        apb_wr     = PSEL && PENABLE && PWRITE;
        ev         = {LINK_UP == 1'b0 && link_q, LINK_UP && !link_q, bit_err};
        status     = 32'h0000_0000;
        status[ST_POWER_ON_SELF_TEST_DONE]     = POWER_ON_SELF_TEST_DONE;
        status[ST_TRAINING]      = TRAINING;
        status[ST_LINK_UP]       = LINK_UP;
        status[ST_SER_ACT]       = SER_ACTIVE;
        status[ST_ROLE_DTE]      = role_dte_q;
        status[ST_LOCKED]        = (meter_q == MTR_RUN);
        status[ST_ERR_SEEN]      = err_seen_q;
        status[ST_REM_LOOP]      = REMOTE_LOOP_CMD && !local_test;
        status[ST_LOOP_LSB +: 2] = loop_q;
        status[ST_PAT_LSB +: 2]  = pat_q;
        ctrl_d     = ctrl_q;
        int_en_d   = int_en_q;
        int_stat_d = int_stat_q;
        prdata_d   = prdata_q;
        pslverr_d  = pslverr_q;
        if (apb_wr) begin
            case (PADDR)
                OFF_CTRL:    ctrl_d     = PWDATA[CTRL_W-1:0];
                OFF_INT_EN:  int_en_d   = PWDATA[EV_W-1:0];
                OFF_INT_CLR: int_stat_d = int_stat_q & ~PWDATA[EV_W-1:0];
                default:     ctrl_d     = ctrl_q;
            endcase
        end
        // New events win over a clear in the same cycle
        int_stat_d = int_stat_d | ev;
        if (apb_setup) begin
            pslverr_d = 1'b0;
            case (PADDR)
                OFF_CTRL:     prdata_d = {27'h000_0000, ctrl_q};
                OFF_STATUS:   prdata_d = status;
                OFF_ERRCNT:   prdata_d = {16'h0000, err_cnt_q};
                OFF_INT_STAT: prdata_d = {29'h0000_0000, int_stat_q};
                OFF_INT_EN:   prdata_d = {29'h0000_0000, int_en_q};
                OFF_INT_CLR:  prdata_d = 32'h0000_0000;
                default: begin
                    prdata_d  = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    // APB register file
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q     <= CTRL_RESET;
            int_en_q   <= INT_EN_RESET;
            int_stat_q <= 3'h0;
            prdata_q   <= 32'h0000_0000;
            pslverr_q  <= 1'b0;
            pready_q   <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            int_en_q   <= int_en_d;
            int_stat_q <= int_stat_d;
            prdata_q   <= prdata_d;
            pslverr_q  <= pslverr_d;
            pready_q   <= apb_setup;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash divider and indicators
    always_comb begin
        blink_cnt_d = blink_cnt_q + 1'b1;
        blink_d     = blink_q;
        if (blink_cnt_q == BLINK_CNT_W'(BLINK_HALF_CYCLES - 1)) begin
            blink_cnt_d = '0;
            blink_d     = !blink_q;
        end
        led_d[0] = POWER_ON_SELF_TEST_DONE || blink_q;
        led_d[1] = LINK_UP || (TRAINING && blink_q);
        led_d[2] = SER_ACTIVE;
        led_d[3] = (local_test || REMOTE_LOOP_CMD) && (!err_seen_q || blink_q);
        led_d[4] = |(int_stat_q & int_en_q);
    end

    // Indicator registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
            link_q      <= 1'b0;
            led_q       <= 5'h00;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q     <= blink_d;
            link_q      <= LINK_UP;
            led_q       <= led_d;
        end
    end

    // Output drive
    assign PRDATA          = prdata_q;
    assign PREADY          = pready_q;
    assign PSLVERR         = pslverr_q;
    assign DSL_TX_DATA     = tx_q;
    assign SER_RX_DATA     = srx_q;
    assign REMOTE_LOOP_REQ = rdl_q;
    assign SER_ROLE_DTE    = role_dte_q;
    assign {IRQ, LED_TEST, LED_SERIAL, LED_LINE, LED_POWER} = led_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    chk_power_led: assert property (POWER_ON_SELF_TEST_DONE |=> LED_POWER)
        else $error("power indicator dark after self-test");
    chk_line_led: assert property (LINK_UP |=> LED_LINE)
        else $error("line indicator dark with link up");
    chk_serial_led: assert property (SER_ACTIVE ##1 SER_ACTIVE |-> LED_SERIAL)
        else $error("serial indicator dark while active");
    chk_test_led: assert property ((local_test && !err_seen_q) |=> LED_TEST)
        else $error("test indicator not solid in test");
    chk_lal_return: assert property (BIT_EN && loop_q == LOOP_LAL |=> SER_RX_DATA == $past(tx_bit))
        else $error("local loop did not return bit");
    chk_lal_clean: assert property (BIT_EN && meter_q == MTR_RUN && loop_q == LOOP_LAL
        && pat_q == PAT_PRBS && !mode_chg |-> !chk_err)
        else $error("local loop with clean pattern shows error");
    chk_remote_loop: assert property (BIT_EN && REMOTE_LOOP_CMD && !local_test
        |=> DSL_TX_DATA == $past(DSL_RX_DATA))
        else $error("remote loop did not return line bit");
    chk_pat_replace: assert property (BIT_EN && pat_q == PAT_PRBS && loop_q == LOOP_OFF
        |=> DSL_TX_DATA == $past(gen_bit))
        else $error("pattern not sent on line");
    chk_meter_runs: assert property (pat_q != PAT_OFF && !mode_chg |=> meter_q != MTR_IDLE)
        else $error("meter idle while pattern runs");
    chk_err_count: assert property (bit_err && err_cnt_q != ERR_CNT_MAX
        |=> err_cnt_q == $past(err_cnt_q) + 16'h0001 && int_stat_q[EV_BIT_ERR])
        else $error("bit error not counted");

    cov_lal_prbs: cover property (loop_q == LOOP_LAL && meter_q == MTR_RUN);
    cov_inject_err: cover property (pat_q == PAT_PRBS_ERR && bit_err);
    cov_irq: cover property (IRQ && LED_TEST);

endmodule : dtlps_top

`default_nettype wire

// >>> dtlps_pkg.sv
/*
 * Shared constants and types of the DSL test-loop, pattern and status block:
 * register map, field positions, reset values, mode enums and timing counts.
 * Assumes a single 100 MHz system clock.
 */
`default_nettype none

package dtlps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 10;           // System clock period
    localparam int unsigned BLINK_HALF_NS  = 250_000_000;  // Half period of a flash
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int unsigned BLINK_CNT_W    = 25;           // Holds BLINK_HALF_CYC

    ////////////////////////////////////////////////////////////////////////////
    // Pattern generator and meter
    localparam int unsigned PRBS_LEN         = 9;          // Shift register stages
    localparam int unsigned PRBS_TAP         = 5;          // Second feedback stage
    localparam logic [8:0]  PRBS_SEED        = 9'h1ff;     // Any non-zero state
    localparam logic [7:0]  INJECT_PERIOD_M1 = 8'hff;      // One bad bit per 256
    localparam logic [3:0]  SYNC_BITS        = 4'h9;       // Bits to fill checker
    localparam logic [15:0] ERR_CNT_MAX      = 16'hffff;   // Counter saturates
    localparam logic        IDLE_BIT         = 1'b1;       // Line level in local loop

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam int unsigned ADDR_W       = 8;
    localparam logic [7:0]  OFF_CTRL     = 8'h00;          // Test mode control
    localparam logic [7:0]  OFF_STATUS   = 8'h04;          // Live status, read only
    localparam logic [7:0]  OFF_ERRCNT   = 8'h08;          // Meter error count
    localparam logic [7:0]  OFF_INT_STAT = 8'h0c;          // Sticky events, read only
    localparam logic [7:0]  OFF_INT_CLR  = 8'h10;          // Write one to clear
    localparam logic [7:0]  OFF_INT_EN   = 8'h14;          // Interrupt enables

    // Control fields
    localparam int unsigned CTRL_LOOP_LSB  = 0;            // Two bits, loop mode
    localparam int unsigned CTRL_PAT_LSB   = 2;            // Two bits, pattern mode
    localparam int unsigned CTRL_PANEL_BIT = 4;            // Front panel switches rule
    localparam int unsigned CTRL_W         = 5;
    localparam logic [4:0]  CTRL_RESET     = 5'h00;

    // Status fields
    localparam int unsigned ST_POWER_ON_SELF_TEST_DONE = 0;
    localparam int unsigned ST_TRAINING  = 1;
    localparam int unsigned ST_LINK_UP   = 2;
    localparam int unsigned ST_SER_ACT   = 3;
    localparam int unsigned ST_ROLE_DTE  = 4;
    localparam int unsigned ST_LOCKED    = 5;
    localparam int unsigned ST_ERR_SEEN  = 6;
    localparam int unsigned ST_REM_LOOP  = 7;
    localparam int unsigned ST_LOOP_LSB  = 8;
    localparam int unsigned ST_PAT_LSB   = 10;

    // Interrupt events
    localparam int unsigned EV_BIT_ERR   = 0;
    localparam int unsigned EV_LINK_UP   = 1;
    localparam int unsigned EV_LINK_LOST = 2;
    localparam int unsigned EV_W         = 3;
    localparam logic [2:0]  INT_EN_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Modes and states
    typedef enum logic [1:0] {LOOP_OFF, LOOP_LAL, LOOP_RDL}     dtlps_loop_e;
    typedef enum logic [1:0] {PAT_OFF, PAT_PRBS, PAT_PRBS_ERR}  dtlps_pat_e;
    typedef enum logic [1:0] {MTR_IDLE, MTR_SYNC, MTR_RUN}      dtlps_meter_e;

endpackage : dtlps_pkg

`default_nettype wire

// >>> dtlps_prbs9.sv
/*
 * Nine-stage maximal-length sequence engine, used both as the pattern
 * generator and as the self-synchronising checker of the bit-error meter.
 * Assumes step pulses arrive once per line bit on the system clock.
 */
`default_nettype none

module dtlps_prbs9 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic step,      // Advance one bit
    input  wire logic clr,       // Reload seed, wins over step
    input  wire logic check,     // Shift in din instead of feedback
    input  wire logic din,       // Received bit in check use
    // Results
    output var  logic bit_o,     // Next sequence bit
    output var  logic err_o      // din differs from prediction
);
    import dtlps_pkg::*;

    logic [PRBS_LEN-1:0] sr_q;   // Sequence state
    logic [PRBS_LEN-1:0] sr_d;   // Next state
    logic                fb;     // Feedback from stages nine and five

    // Feedback and comparison
    always_comb begin
        fb    = sr_q[PRBS_LEN-1] ^ sr_q[PRBS_TAP-1];
        bit_o = fb;
        err_o = check & (din != fb);
        sr_d  = sr_q;
        if (clr) begin
            sr_d = PRBS_SEED;
        end else if (step) begin
            // Checker locks by loading received bits; an all-zero line locks it too
            sr_d = {sr_q[PRBS_LEN-2:0], check ? din : fb};
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= PRBS_SEED;
        end else begin
            sr_q <= sr_d;
        end
    end

endmodule : dtlps_prbs9

`default_nettype wire

// >>> dtlps_far_end.sv
/*
 * Far-end modem model on the line side of the block.
 * Assumes one line bit per BIT_EN strobe on the shared system clock.
 */
`default_nettype none
module dtlps_far_end (
    // Clock, reset and bit strobe
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic bit_en,
    // Line
    input  wire logic line_in,   // Bits sent by the near end
    input  wire logic loop_req,  // Near end asks for a loop
    output var  logic line_out   // Bits sent back toward the near end
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic ROLE_SUBSCRIBER = 1'b1;  // Opposite role to near end, same rate
    ////////////////////////////////////////////////////////////////////////////
    // Loop line data back, else an alternating non-pattern stream
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            line_out <= 1'b0;
        end else if (bit_en) begin
            line_out <= loop_req ? line_in : ~line_out;
        end
    end
endmodule : dtlps_far_end
`default_nettype wire

// >>> dtlps_top_tb_top.sv
/*
 * Bench of the test-loop block: APB tasks set modes, far-end model on line.
 * Assumes the package and far-end model are compiled first.
 */
`default_nettype none
module dtlps_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dtlps_pkg::*;
    logic        mclk = 0, rst_n = 0, up = 0, psel = 0, pen = 0, pwr = 0;
    logic        bit_en = 0, ser_tx = 0, rx, pready, pslverr, dsl_tx, rl_req;
    logic        led_s, led_t, irq, slverr, led_p, led_l, role, srx;
    logic        strap = 1, rcmd = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    int          n_mismatch = 0, comparisons = 0;
    always #5 mclk = ~mclk;
    // Line bit every other cycle, serial data toggling
    always @(posedge mclk) begin
        bit_en <= ~bit_en;
        ser_tx <= ser_tx ^ bit_en;
    end
    dtlps_top #(.BLINK_HALF_CYCLES(4)) dtlps_top_inst (.MCLK(mclk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PANEL_LOOP(2'h0),
        .PANEL_PAT(2'h0), .ROLE_STRAP_DTE(strap), .POWER_ON_SELF_TEST_DONE(up), .TRAINING(1'b0),
        .LINK_UP(up), .SER_ACTIVE(up), .BIT_EN(bit_en), .SER_TX_DATA(ser_tx),
        .DSL_RX_DATA(rx), .REMOTE_LOOP_CMD(rcmd), .DSL_TX_DATA(dsl_tx), .SER_RX_DATA(srx),
        .REMOTE_LOOP_REQ(rl_req), .SER_ROLE_DTE(role), .LED_POWER(led_p), .LED_LINE(led_l),
        .LED_SERIAL(led_s), .LED_TEST(led_t), .IRQ(irq));
    dtlps_far_end dtlps_far_end_inst (.mclk(mclk), .rst_n(rst_n), .bit_en(bit_en),
        .line_in(dsl_tx), .loop_req(rl_req), .line_out(rx));
    ////////////////////////////////////////////////////////////////////////////
    // One APB transfer, held until PREADY is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge mclk) pen <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        slverr = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge mclk);
    endtask : apb
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1; up <= 1;
        @(posedge mclk);
        apb(0, OFF_CTRL, 0); chk("ctrl", 32'h0, r);
        apb(0, 8'h40, 0); chk("unmapped", 32'h1, slverr);
        apb(1, OFF_INT_EN, 32'h1);
        apb(1, OFF_CTRL, 32'h5); repeat (400) @(posedge mclk);
        apb(0, OFF_ERRCNT, 0); chk("lal errcnt", 32'h0, r);
        apb(0, OFF_STATUS, 0); chk("locked", 32'h1, r[ST_LOCKED]);
        chk("role", 32'h1, r[ST_ROLE_DTE]);
        chk("role pin", 32'h1, role);
        chk("power led", 32'h1, led_p);
        chk("line led", 32'h1, led_l);
        chk("test led", 32'h1, led_t);
        chk("idle line", 32'h1, dsl_tx);
        chk("serial led", 32'h1, led_s);
        apb(1, OFF_CTRL, 32'h4); repeat (100) @(posedge mclk);
        chk("error irq", 32'h1, irq);
        apb(1, OFF_INT_EN, 0); repeat (3) @(posedge mclk);
        chk("masked irq", 32'h0, irq);
        apb(1, OFF_CTRL, 32'h6); apb(1, OFF_INT_CLR, 32'h7);
        repeat (400) @(posedge mclk);
        chk("loop req", 32'h1, rl_req);
        apb(0, OFF_ERRCNT, 0); chk("rdl errcnt", 32'h0, r);
        apb(0, OFF_INT_STAT, 0); chk("int stat", 32'h0, r[0]);
        apb(1, OFF_CTRL, 32'ha); repeat (900) @(posedge mclk);
        apb(0, OFF_ERRCNT, 0); chk("injected", 32'h1, r != 0);
        apb(1, OFF_CTRL, 0); rcmd <= 1; repeat (20) @(posedge mclk);
        apb(0, OFF_STATUS, 0); chk("remote cmd", 32'h1, r[ST_REM_LOOP]);
        chk("remote echo", !rx, dsl_tx);
        chk("serial rx", !rx, srx);
        chk("remote test led", 32'h1, led_t);
        chk("no loop req", 32'h0, rl_req);
        final_report();
    end
    // Watchdog against a hang
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
endmodule : dtlps_top_tb_top
`default_nettype wire
